// ===== rtl/liion_charge_cycle_control.sv
`timescale 1ns/1ps
// Function
// - below 2 V trickle threshold charge linearly at fixed 45 mA.
// - between 2 V and 3 V use switch mode at pre-charge current.
// - pre-charge current 450 mA, reducible to 100 mA by a control bit.
// - 45 minute safety timer runs through trickle and pre-charge.
// - above 3 V fast charge, 550 mA to 1.15 A in 100 mA steps, 1.2 A at the top code.
// - battery current ramps gradually toward each new target, except trickle current, which is set at once.
// - constant-voltage mode once cell reaches programmable float voltage.
// - in constant voltage stop when current falls to termination level.
// - 360 minute safety timer starts when fast charge begins.
// - charging off while enable pin high or headroom below shutdown.
// - input current limit selectable 100, 500, 800, 1200 mA or unlimited.
// - dynamic input limit with threshold 4.0 V to 4.75 V, enable bit.
// - dynamic limit enables after 100 ms above threshold; status readable.
// - clearing the enable bit turns the dynamic limit off.
// - after completion restart when cell drops below float minus 120 mV.
// - automatic recharge can be disabled by a control bit.
// - with valid input and no battery, detection repeats until found.
// - detection outcome shows in a readable battery-present flag.
// - removal seen by detection or id comparator raises loss interrupt.
// - cell above float plus 100 mV past deglitch stops charge, alarms.
// - overvoltage check only while the charger is enabled.
// - after overvoltage stop resume once cell falls below threshold.
// - termination must persist 170 ms before cycle ends.
module liion_charge_cycle_control
  import liion_charge_pkg::*;
#(
  parameter int MS_CYCLES       = MS_CYCLES_DEF,
  parameter int PRE_TIMER_MS    = PRE_TIMER_MS_DEF,
  parameter int FAST_TIMER_MS   = FAST_TIMER_MS_DEF,
  parameter int OVP_DEGLITCH_MS = OVP_DEGLITCH_MS_DEF
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic [3:0]      i_addr,
  input  wire logic [7:0]      i_wdata,
  input  wire logic            i_we,
  input  wire logic            i_re,
  output logic      [7:0]      o_rdata,
  input  wire sense_s          i_sense,
  output logic                 o_charge_on,
  output logic                 o_linear_mode,
  output logic                 o_switch_mode,
  output logic                 o_cv_mode,
  output logic      [MA_W-1:0] o_charge_ma,
  output logic      [2:0]      o_input_limit_code,
  output logic      [5:0]      o_float_code,
  output logic      [3:0]      o_term_code,
  output logic      [1:0]      o_dynamic_input_limit_threshold_code,
  output logic                 o_dynamic_input_limit,
  output logic                 o_det_source,
  output logic                 o_battery_present_flag,
  output logic                 o_battery_loss_interrupt
);

  function automatic logic [CNT_W-1:0] dglitch(input logic [CNT_W-1:0] c,
                                               input logic cond, input logic tick);
    dglitch = !cond ? '0 : (tick && c != '1) ? c + 12'h001 : c;
  endfunction : dglitch

  function automatic charge_state_e by_level(input sense_s s);
    by_level = s.cell_below_trickle ? ST_TRICKLE : s.cell_below_pre ? ST_PRE : ST_FAST;
  endfunction : by_level

  function automatic logic pre_grp(input charge_state_e s);
    pre_grp = (s == ST_TRICKLE) || (s == ST_PRE);
  endfunction : pre_grp

  function automatic logic fast_grp(input charge_state_e s);
    fast_grp = (s == ST_FAST) || (s == ST_CV);
  endfunction : fast_grp

  // input synchroniser
  sense_s sync1_r;
  sense_s sn_r;
  always_ff @(posedge i_clk)
  begin
    sync1_r <= i_sense;
    sn_r    <= sync1_r;
  end

  // register bus
  logic [2:0]      ctrl_r,   ctrl_nxt;
  logic [2:0]      fast_r,   fast_nxt;
  logic [5:0]      float_r,  float_nxt;
  logic [3:0]      term_r,   term_nxt;
  logic [2:0]      ilim_r,   ilim_nxt;
  logic [1:0]      diclth_r, diclth_nxt;
  logic [2:0]      flags_r,  flags_nxt;
  logic [7:0]      rdata_r,  rdata_nxt;
  logic [2:0]      flag_set;
  logic [7:0]      status_v;

  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    fast_nxt   = fast_r;
    float_nxt  = float_r;
    term_nxt   = term_r;
    ilim_nxt   = ilim_r;
    diclth_nxt = diclth_r;
    rdata_nxt  = 8'h00;
    if (i_we)
    begin
      unique case (i_addr)
        ADDR_CTRL:   ctrl_nxt   = i_wdata[2:0];
        ADDR_FAST:   fast_nxt   = i_wdata[2:0];
        ADDR_FLOAT:  float_nxt  = i_wdata[5:0];
        ADDR_TERM:   term_nxt   = i_wdata[3:0];
        ADDR_ILIM:   ilim_nxt   = i_wdata[2:0];
        ADDR_DICLTH: diclth_nxt = i_wdata[1:0];
        default:     ;
      endcase
    end
    // hardware set wins over write-one clear
    flags_nxt = (flags_r & ~((i_we && i_addr == ADDR_FLAGS) ? i_wdata[2:0] : 3'h0)) | flag_set;
    if (i_re)
    begin
      unique case (i_addr)
        ADDR_CTRL:   rdata_nxt = {5'h00, ctrl_r};
        ADDR_FAST:   rdata_nxt = {5'h00, fast_r};
        ADDR_FLOAT:  rdata_nxt = {2'h0, float_r};
        ADDR_TERM:   rdata_nxt = {4'h0, term_r};
        ADDR_ILIM:   rdata_nxt = {5'h00, ilim_r};
        ADDR_DICLTH: rdata_nxt = {6'h00, diclth_r};
        ADDR_STATUS: rdata_nxt = status_v;
        ADDR_FLAGS:  rdata_nxt = {5'h00, flags_r};
        default:     rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ctrl_r   <= CTRL_RST;
      fast_r   <= FAST_RST;
      float_r  <= FLOAT_RST;
      term_r   <= TERM_RST;
      ilim_r   <= ILIM_RST;
      diclth_r <= DICLTH_RST;
      flags_r  <= FLAGS_RST;
      rdata_r  <= 8'h00;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      fast_r   <= fast_nxt;
      float_r  <= float_nxt;
      term_r   <= term_nxt;
      ilim_r   <= ilim_nxt;
      diclth_r <= diclth_nxt;
      flags_r  <= flags_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // charge sequencer
  charge_state_e   state_r, state_nxt;
  logic [PSC_W-1:0] psc_r, psc_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic [CNT_W-1:0] term_cnt_r, term_cnt_nxt;
  logic [CNT_W-1:0] ovp_cnt_r, ovp_cnt_nxt;
  logic [CNT_W-1:0] dynamic_input_limit_cnt_r, dynamic_input_limit_cnt_nxt;
  logic [CNT_W-1:0] det_cnt_r, det_cnt_nxt;
  logic [MA_W-1:0]  ramp_r, ramp_nxt;
  logic [MA_W-1:0]  target;
  logic             present_r, present_nxt;
  logic             dynamic_input_limit_r, dynamic_input_limit_nxt;
  logic             tick;
  logic             charge_ok;
  logic             tmr_expired;
  logic             on_r, on_nxt;
  logic             lin_r, lin_nxt;
  logic             swm_r, swm_nxt;
  logic             cvm_r, cvm_nxt;
  logic             probe_r, probe_nxt;

  assign status_v = {1'b0, state_r == ST_FAULT, state_r == ST_OVP, state_r == ST_DONE,
                     state_r == ST_CV, state_r == ST_FAST, dynamic_input_limit_r, present_r};

  always_comb
  begin
    tick      = (psc_r == PSC_W'(MS_CYCLES - 1));
    psc_nxt   = tick ? '0 : psc_r + 16'h0001;
    charge_ok = sn_r.input_valid && !sn_r.charger_enable_low_pin && !sn_r.auto_shutdown;
    state_nxt   = state_r;
    present_nxt = present_r;
    flag_set    = 3'h0;
    tmr_expired = (pre_grp(state_r) && tmr_r >= TMR_W'(PRE_TIMER_MS)) ||
                  (fast_grp(state_r) && tmr_r >= TMR_W'(FAST_TIMER_MS));
    term_cnt_nxt = dglitch(term_cnt_r, state_r == ST_CV && sn_r.term_reached, tick);
    ovp_cnt_nxt  = dglitch(ovp_cnt_r, charge_ok && state_r != ST_OFF
                           && sn_r.cell_above_ovp, tick);
    det_cnt_nxt  = dglitch(det_cnt_r, state_r == ST_DETECT, tick);
    if (!charge_ok)
    begin
      state_nxt = ST_OFF;
      if (!sn_r.input_valid)
        present_nxt = 1'b0;
    end
    else if (present_r && sn_r.battery_id_removed)
    begin
      flag_set[FLAG_LOSS] = 1'b1;
      present_nxt         = 1'b0;
      state_nxt           = ST_DETECT;
    end
    else if (state_r != ST_OVP && state_r != ST_FAULT
             && ovp_cnt_r >= CNT_W'(OVP_DEGLITCH_MS))
    begin
      state_nxt           = ST_OVP;
      flag_set[FLAG_OVP]  = 1'b1;
    end
    else if (tmr_expired)
    begin
      state_nxt            = ST_FAULT;
      flag_set[FLAG_TIMER] = 1'b1;
    end
    else
    begin
      unique case (state_r)
        ST_OFF:     state_nxt = ST_DETECT;
        ST_DETECT:
        begin
          if (det_cnt_r >= CNT_W'(DET_SOURCE_MS))
          begin
            det_cnt_nxt = '0;
            if (sn_r.battery_present_flag)
            begin
              present_nxt = 1'b1;
              state_nxt   = by_level(sn_r);
            end
            else
            begin
              flag_set[FLAG_LOSS] = present_r;
              present_nxt         = 1'b0;
            end
          end
        end
        ST_TRICKLE: if (!sn_r.cell_below_trickle) state_nxt = by_level(sn_r);
        ST_PRE:     if (!sn_r.cell_below_pre) state_nxt = ST_FAST;
        ST_FAST:    if (sn_r.cell_at_float) state_nxt = ST_CV;
        ST_CV:      if (term_cnt_r >= CNT_W'(TERM_DEGLITCH_MS)) state_nxt = ST_DONE;
        ST_DONE:
        begin
          if (!ctrl_r[CTRL_RCHG_DIS] && sn_r.cell_below_recharge)
            state_nxt = ST_DETECT;
        end
        ST_FAULT:   state_nxt = ST_FAULT;
        ST_OVP:     if (!sn_r.cell_above_ovp) state_nxt = by_level(sn_r);
      endcase
    end
    // safety timer restarts on entering each timed phase group
    if ((pre_grp(state_nxt) && !pre_grp(state_r)) || (fast_grp(state_nxt) && !fast_grp(state_r)))
      tmr_nxt = '0;
    else if (tick && (pre_grp(state_r) || fast_grp(state_r)) && tmr_r != '1)
      tmr_nxt = tmr_r + 25'h0000001;
    else
      tmr_nxt = tmr_r;
    // dynamic input limit qualification
    dynamic_input_limit_cnt_nxt = dglitch(dynamic_input_limit_cnt_r, ctrl_r[CTRL_DYNAMIC_LIMIT_ENABLE_BIT] && sn_r.input_valid
                           && !sn_r.input_below_dynamic_input_limit, tick);
    if (!ctrl_r[CTRL_DYNAMIC_LIMIT_ENABLE_BIT] || !sn_r.input_valid)
      dynamic_input_limit_nxt = 1'b0;
    else if (dynamic_input_limit_cnt_r >= CNT_W'(DYNAMIC_INPUT_LIMIT_DEGLITCH_MS))
      dynamic_input_limit_nxt = 1'b1;
    else
      dynamic_input_limit_nxt = dynamic_input_limit_r;
    // charge current target and ramp
    unique case (state_r)
      ST_TRICKLE: target = TRICKLE_MA;
      ST_PRE:     target = ctrl_r[CTRL_PRE_LOW] ? PRE_LOW_MA : PRE_MA;
      ST_FAST,
      ST_CV:      target = (fast_r == 3'h7) ? FAST_MAX_MA
                           : FAST_BASE_MA + MA_W'(fast_r) * FAST_STEP_MA;
      default:    target = '0;
    endcase
    ramp_nxt = ramp_r;
    if (state_nxt == ST_TRICKLE)
      ramp_nxt = TRICKLE_MA;
    else if (tick && ramp_r < target)
      ramp_nxt = (target - ramp_r > RAMP_STEP_MA) ? ramp_r + RAMP_STEP_MA : target;
    else if (tick && ramp_r > target)
      ramp_nxt = (ramp_r - target > RAMP_STEP_MA) ? ramp_r - RAMP_STEP_MA : target;
    // mode outputs registered from the next state
    on_nxt    = pre_grp(state_nxt) || fast_grp(state_nxt);
    lin_nxt   = state_nxt == ST_TRICKLE;
    swm_nxt   = state_nxt == ST_PRE || fast_grp(state_nxt);
    cvm_nxt   = state_nxt == ST_CV;
    probe_nxt = state_nxt == ST_DETECT;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_r    <= ST_OFF;
      psc_r      <= '0;
      tmr_r      <= '0;
      term_cnt_r <= '0;
      ovp_cnt_r  <= '0;
      dynamic_input_limit_cnt_r <= '0;
      det_cnt_r  <= '0;
      ramp_r     <= '0;
      present_r  <= 1'b0;
      dynamic_input_limit_r     <= 1'b0;
      on_r       <= 1'b0;
      lin_r      <= 1'b0;
      swm_r      <= 1'b0;
      cvm_r      <= 1'b0;
      probe_r    <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      psc_r      <= psc_nxt;
      tmr_r      <= tmr_nxt;
      term_cnt_r <= term_cnt_nxt;
      ovp_cnt_r  <= ovp_cnt_nxt;
      dynamic_input_limit_cnt_r <= dynamic_input_limit_cnt_nxt;
      det_cnt_r  <= det_cnt_nxt;
      ramp_r     <= ramp_nxt;
      present_r  <= present_nxt;
      dynamic_input_limit_r     <= dynamic_input_limit_nxt;
      on_r       <= on_nxt;
      lin_r      <= lin_nxt;
      swm_r      <= swm_nxt;
      cvm_r      <= cvm_nxt;
      probe_r    <= probe_nxt;
    end
  end

  assign o_rdata                  = rdata_r;
  assign o_charge_on              = on_r;
  assign o_linear_mode            = lin_r;
  assign o_switch_mode            = swm_r;
  assign o_cv_mode                = cvm_r;
  assign o_charge_ma              = ramp_r;
  assign o_input_limit_code       = ilim_r;
  assign o_float_code             = float_r;
  assign o_term_code              = term_r;
  assign o_dynamic_input_limit_threshold_code    = diclth_r;
  assign o_dynamic_input_limit    = dynamic_input_limit_r;
  assign o_det_source             = probe_r;
  assign o_battery_present_flag   = present_r;
  assign o_battery_loss_interrupt = flags_r[FLAG_LOSS];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  trickle_linear_a: assert property (state_r == ST_TRICKLE |-> o_linear_mode && !o_switch_mode
    && o_charge_ma == TRICKLE_MA) else $error("trickle not linear at fixed current");
  pre_current_a: assert property (state_r == ST_PRE && ctrl_r[CTRL_PRE_LOW] |-> target == PRE_LOW_MA)
    else $error("reduced pre-charge current wrong");
  ramp_step_a: assert property ($past(state_r) != ST_TRICKLE && state_r != ST_TRICKLE |->
    (ramp_r >= $past(ramp_r) ? ramp_r - $past(ramp_r) : $past(ramp_r) - ramp_r) <= RAMP_STEP_MA)
    else $error("charge current stepped too far");
  timer_fault_a: assert property (charge_ok && tmr_expired && !(present_r
    && sn_r.battery_id_removed) && ovp_cnt_r < CNT_W'(OVP_DEGLITCH_MS)
    |=> state_r == ST_FAULT && flags_r[FLAG_TIMER]) else $error("timer expiry missed");
  disable_pin_a: assert property (sn_r.charger_enable_low_pin |=> state_r == ST_OFF
    ##1 !o_charge_on) else $error("charging while disabled");
  dynamic_input_limit_off_a: assert property (!ctrl_r[CTRL_DYNAMIC_LIMIT_ENABLE_BIT] |=> !o_dynamic_input_limit)
    else $error("dynamic limit on without enable");
  recharge_off_a: assert property (state_r == ST_DONE && ctrl_r[CTRL_RCHG_DIS] |=>
    state_r inside {ST_DONE, ST_OFF, ST_DETECT, ST_OVP}) else $error("recharge while off");
  term_hold_a: assert property (state_r == ST_CV ##1 state_r == ST_DONE |->
    $past(term_cnt_r) >= CNT_W'(TERM_DEGLITCH_MS)) else $error("termination not held");
  loss_flag_a: assert property (charge_ok && present_r && sn_r.battery_id_removed |=>
    flags_r[FLAG_LOSS] && !present_r) else $error("removal not flagged");
  ovp_resume_a: assert property (state_r == ST_OVP && charge_ok && !sn_r.cell_above_ovp
    && !(present_r && sn_r.battery_id_removed) |=> o_charge_on)
    else $error("no resume after overvoltage");
  dynamic_input_limit_qual_a: assert property (!dynamic_input_limit_r ##1 dynamic_input_limit_r |-> $past(dynamic_input_limit_cnt_r) >= CNT_W'(DYNAMIC_INPUT_LIMIT_DEGLITCH_MS))
    else $error("dynamic limit enabled early");

  reach_cv_c: cover property (state_r == ST_FAST ##1 state_r == ST_CV);
  reach_done_c: cover property (state_r == ST_CV ##1 state_r == ST_DONE);
  reach_ovp_c: cover property (state_r == ST_OVP ##1 o_charge_on);
  dynamic_input_limit_on_c: cover property (!o_dynamic_input_limit ##1 o_dynamic_input_limit);
  reach_fault_c: cover property (o_charge_on ##1 state_r == ST_FAULT);

endmodule : liion_charge_cycle_control

// ===== rtl/liion_charge_pkg.sv
package liion_charge_pkg;
  // clock and time base
  localparam int CLK_NS            = 25;
  localparam int MS_NS             = 1000000;
  localparam int MS_CYCLES_DEF     = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_PER_MIN        = 60000;
  localparam int PRE_TIMER_MIN     = 45;
  localparam int FAST_TIMER_MIN    = 360;
  localparam int PRE_TIMER_MS_DEF  = PRE_TIMER_MIN * MS_PER_MIN;
  localparam int FAST_TIMER_MS_DEF = FAST_TIMER_MIN * MS_PER_MIN;
  localparam int TERM_DEGLITCH_MS  = 170;
  localparam int DYNAMIC_INPUT_LIMIT_DEGLITCH_MS  = 100;
  localparam int DET_SOURCE_MS     = 340;
  localparam int OVP_DEGLITCH_MS_DEF = 10;
  localparam int CNT_W             = 12;
  localparam int TMR_W             = 25;
  localparam int PSC_W             = 16;
  // currents in mA
  localparam int MA_W                    = 11;
  localparam logic [MA_W-1:0] TRICKLE_MA   = 11'h02d;
  localparam logic [MA_W-1:0] PRE_MA       = 11'h1c2;
  localparam logic [MA_W-1:0] PRE_LOW_MA   = 11'h064;
  localparam logic [MA_W-1:0] FAST_BASE_MA = 11'h226;
  localparam logic [MA_W-1:0] FAST_STEP_MA = 11'h064;
  localparam logic [MA_W-1:0] FAST_MAX_MA  = 11'h4b0;
  localparam logic [MA_W-1:0] RAMP_STEP_MA = 11'h019;
  // register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_FAST   = 4'h1;
  localparam logic [3:0] ADDR_FLOAT  = 4'h2;
  localparam logic [3:0] ADDR_TERM   = 4'h3;
  localparam logic [3:0] ADDR_ILIM   = 4'h4;
  localparam logic [3:0] ADDR_DICLTH = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_FLAGS  = 4'h7;
  localparam int CTRL_PRE_LOW  = 0;
  localparam int CTRL_RCHG_DIS = 1;
  localparam int CTRL_DYNAMIC_LIMIT_ENABLE_BIT  = 2;
  localparam int FLAG_LOSS     = 0;
  localparam int FLAG_TIMER    = 1;
  localparam int FLAG_OVP      = 2;
  localparam logic [2:0] CTRL_RST   = 3'h0;
  localparam logic [2:0] FAST_RST   = 3'h0;
  localparam logic [5:0] FLOAT_RST  = 6'h1e;
  localparam logic [3:0] TERM_RST   = 4'h2;
  localparam logic [2:0] ILIM_RST   = 3'h1;
  localparam logic [1:0] DICLTH_RST = 2'h0;
  localparam logic [2:0] FLAGS_RST  = 3'h0;

  typedef enum logic [8:0] {
    ST_OFF     = 9'h001,
    ST_DETECT  = 9'h002,
    ST_TRICKLE = 9'h004,
    ST_PRE     = 9'h008,
    ST_FAST    = 9'h010,
    ST_CV      = 9'h020,
    ST_DONE    = 9'h040,
    ST_FAULT   = 9'h080,
    ST_OVP     = 9'h100
  } charge_state_e;

  // comparator levels from the analog side
  typedef struct packed {
    logic cell_below_trickle;
    logic cell_below_pre;
    logic cell_at_float;
    logic cell_below_recharge;
    logic cell_above_ovp;
    logic term_reached;
    logic input_valid;
    logic input_below_dynamic_input_limit;
    logic auto_shutdown;
    logic charger_enable_low_pin;
    logic battery_id_removed;
    logic battery_present_flag;
  } sense_s;
endpackage : liion_charge_pkg

// ===== dv/cell_source_model.sv
`timescale 1ns/1ps
// input source and single cell seen through the comparators
// ctl: [0] source valid [1] enable pin high [2] low headroom [3] id open
//      [4] cell fitted [5] taper current low [6] input sagging
module cell_source_model
  import liion_charge_pkg::*;
(
  input  wire logic [12:0] i_cell_mv,
  input  wire logic [5:0]  i_float_code,
  input  wire logic [7:0]  i_ctl,
  input  wire logic        i_det_source,
  output sense_s           o_sense
);
  logic [12:0] float_mv;

  always_comb
  begin
    float_mv                       = 13'he10 + 13'(i_float_code) * 13'h014;
    o_sense.cell_below_trickle     = i_cell_mv < 13'h7d0;
    o_sense.cell_below_pre         = i_cell_mv < 13'hbb8;
    o_sense.cell_at_float          = i_cell_mv >= float_mv;
    o_sense.cell_below_recharge    = i_cell_mv < float_mv - 13'h078;
    o_sense.cell_above_ovp         = i_cell_mv > float_mv + 13'h064;
    o_sense.term_reached           = i_ctl[5];
    o_sense.input_valid            = i_ctl[0];
    o_sense.input_below_dynamic_input_limit       = i_ctl[6];
    o_sense.auto_shutdown          = i_ctl[2];
    o_sense.charger_enable_low_pin = i_ctl[1];
    o_sense.battery_id_removed     = i_ctl[3];
    // a fitted cell only answers while the probe runs
    o_sense.battery_present_flag                 = i_ctl[4] & i_det_source;
  end
endmodule : cell_source_model

// ===== dv/liion_charge_cycle_control_test.sv
`timescale 1ns/1ps
module liion_charge_cycle_control_test;
  import liion_charge_pkg::*;
  localparam int MSC = 4;
  logic            i_clk, i_rst, i_we, i_re;
  logic [3:0]      i_addr;
  logic [7:0]      i_wdata, o_rdata, ctl;
  logic [12:0]     mv;
  sense_s          sense;
  logic            charge_on, linear, sw, cv, dil, dets, pres, loss, sw_q, re_d;
  logic [MA_W-1:0] ma, ma_q;
  logic [2:0]      ilim;
  logic [5:0]      flc;
  logic [3:0]      tmc;
  logic [1:0]      dtc;
  logic [7:0]      exp_q[$];
  logic [7:0]      rst_v [8] = '{8'(CTRL_RST), 8'(FAST_RST), 8'(FLOAT_RST), 8'(TERM_RST),
                                 8'(ILIM_RST), 8'(DICLTH_RST), 8'h00, 8'(FLAGS_RST)};
  int              n_fail = 0, samples_checked = 0, cyc = 0, seed;

  liion_charge_cycle_control #(.MS_CYCLES(MSC), .PRE_TIMER_MS(50), .FAST_TIMER_MS(400),
    .OVP_DEGLITCH_MS(2)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .o_rdata(o_rdata), .i_sense(sense), .o_charge_on(charge_on),
    .o_linear_mode(linear), .o_switch_mode(sw), .o_cv_mode(cv), .o_charge_ma(ma),
    .o_input_limit_code(ilim), .o_float_code(flc), .o_term_code(tmc),
    .o_dynamic_input_limit_threshold_code(dtc), .o_dynamic_input_limit(dil), .o_det_source(dets),
    .o_battery_present_flag(pres), .o_battery_loss_interrupt(loss));

  cell_source_model i_model (.i_cell_mv(mv), .i_float_code(flc), .i_ctl(ctl),
    .i_det_source(dets), .o_sense(sense));

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic cmp_val(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t rdata=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_we    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_we    <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    i_re   <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_re   <= 1'b0;
    @(posedge i_clk);
  endtask : rd

  function automatic logic [10:0] pick(input int k);
    case (k)
      0: pick = 11'(charge_on);
      1: pick = 11'(sw);
      2: pick = 11'(cv);
      3: pick = 11'(dil);
      4: pick = 11'(dets);
      5: pick = 11'(loss);
      default: pick = ma;
    endcase
  endfunction : pick

  // bounded wait on an output, c returns the cycles spent
  task automatic wt(input int k, input logic [10:0] v, input int n, output int c);
    c = 0;
    while (pick(k) !== v)
    begin
      @(negedge i_clk);
      c++;
      if (c > n)
      begin
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, pick(k), v);
        wrap_up();
      end
    end
    @(posedge i_clk);
  endtask : wt

  always @(posedge i_clk)
  begin
    re_d <= i_re;
    cyc  <= cyc + 1;
  end

  // read data stand one cycle after the strobe; current moves in small steps
  always @(negedge i_clk)
  begin
    if (re_d === 1'b1)
      cmp_data(o_rdata, exp_q.pop_front());
    if (sw === 1'b1 && sw_q === 1'b1)
      cmp_val(11'((ma > ma_q ? ma - ma_q : ma_q - ma) <= RAMP_STEP_MA), 11'h001);
    sw_q = sw;
    ma_q = ma;
  end

  initial
  begin
    int i, c, s0, flt;
    logic [5:0] fv;
    logic [7:0] tcode, dcode;
    seed    = 95471;
    i_rst   = 1'b1;
    i_we    = 1'b0;
    i_re    = 1'b0;
    i_addr  = 4'h0;
    i_wdata = 8'h00;
    ctl     = 8'h00;
    mv      = 13'h0000;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    for (i = 0; i < 8; i++)
      rd(4'(i), rst_v[i]);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    for (i = 0; i < 5; i++)
    begin
      wr(ADDR_ILIM, 8'(i));
      cmp_val(11'(ilim), 11'(i));
    end
    fv = 6'($unsigned($random(seed)) % 56);
    wr(ADDR_FLOAT, 8'(fv));
    cmp_val(11'(flc), 11'(fv));
    tcode = 8'($unsigned($random(seed)) % 11);
    wr(ADDR_TERM, tcode);
    rd(ADDR_TERM, tcode);
    cmp_val(11'(tmc), 11'(tcode));
    dcode = 8'($unsigned($random(seed)) % 4);
    wr(ADDR_DICLTH, dcode);
    rd(ADDR_DICLTH, dcode);
    cmp_val(11'(dtc), 11'(dcode));
    flt = 3600 + 20 * int'(fv);
    ctl <= 8'h41;
    wr(ADDR_CTRL, 8'h04);
    wt(4, 11'h001, 1400, c);
    repeat (400) @(posedge i_clk);
    cmp_val(11'(dil), 11'h000);
    ctl[6] <= 1'b0;
    wt(3, 11'h001, 500, c);
    cmp_val(11'(c >= 395 && c <= 415), 11'h001);
    rd(ADDR_STATUS, 8'h02);
    wr(ADDR_CTRL, 8'h00);
    wt(3, 11'h000, 3, c);
    wt(4, 11'h001, 20, c);
    cmp_val(11'(charge_on), 11'h000);
    mv     <= 13'(1500);
    ctl[4] <= 1'b1;
    wt(0, 11'h001, 1400, c);
    s0 = cyc;
    cmp_val(11'(linear), 11'h001);
    cmp_val(ma, TRICKLE_MA);
    cmp_val(11'(pres), 11'h001);
    mv <= 13'(2500);
    wt(1, 11'h001, 12, c);
    wt(6, PRE_MA, 120, c);
    wr(ADDR_CTRL, 8'h01);
    wt(6, PRE_LOW_MA, 100, c);
    wt(0, 11'h000, 200, c);
    cmp_val(11'(cyc - s0 >= 190 && cyc - s0 <= 215), 11'h001);
    rd(ADDR_FLAGS, 8'h02);
    rd(ADDR_STATUS, 8'h41);
    wr(ADDR_FLAGS, 8'h02);
    rd(ADDR_FLAGS, 8'h00);
    ctl[2] <= 1'b1;
    repeat (4) @(posedge i_clk);
    ctl[2] <= 1'b0;
    mv     <= 13'(3300);
    wr(ADDR_CTRL, 8'h00);
    wt(0, 11'h001, 1400, c);
    rd(ADDR_STATUS, 8'h05);
    for (i = 0; i < 8; i++)
    begin
      wr(ADDR_FAST, 8'(i));
      wt(6, i == 7 ? FAST_MAX_MA : FAST_BASE_MA + FAST_STEP_MA * 11'(i), 120, c);
    end
    ctl[1] <= 1'b1;
    wt(0, 11'h000, 5, c);
    mv <= 13'(flt + 150);
    repeat (40) @(posedge i_clk);
    rd(ADDR_FLAGS, 8'h00);
    ctl[1] <= 1'b0;
    mv     <= 13'(3300);
    wt(0, 11'h001, 1400, c);
    mv <= 13'(flt + 150);
    repeat (6) @(posedge i_clk);
    cmp_val(11'(charge_on), 11'h001);
    wt(0, 11'h000, 20, c);
    rd(ADDR_FLAGS, 8'h04);
    mv <= 13'(flt - 50);
    wt(0, 11'h001, 20, c);
    wr(ADDR_FLAGS, 8'h04);
    mv <= 13'(flt);
    wt(2, 11'h001, 10, c);
    rd(ADDR_STATUS, 8'h09);
    ctl[5] <= 1'b1;
    wt(0, 11'h000, 720, c);
    cmp_val(11'(c >= 670 && c <= 700), 11'h001);
    rd(ADDR_STATUS, 8'h11);
    mv <= 13'(flt - 130);
    wt(4, 11'h001, 10, c);
    ctl[5] <= 1'b0;
    wt(0, 11'h001, 1400, c);
    ctl[2] <= 1'b1;
    wt(0, 11'h000, 5, c);
    ctl[2] <= 1'b0;
    wt(0, 11'h001, 1400, c);
    mv     <= 13'(flt);
    ctl[5] <= 1'b1;
    wt(0, 11'h000, 720, c);
    wr(ADDR_CTRL, 8'h02);
    mv <= 13'(flt - 130);
    repeat (40) @(posedge i_clk);
    cmp_val(11'(dets), 11'h000);
    cmp_val(11'(charge_on), 11'h000);
    ctl[5] <= 1'b0;
    wr(ADDR_CTRL, 8'h00);
    wt(0, 11'h001, 1400, c);
    ctl[3] <= 1'b1;
    ctl[4] <= 1'b0;
    wt(5, 11'h001, 5, c);
    rd(ADDR_FLAGS, 8'h01);
    ctl[3] <= 1'b0;
    wr(ADDR_FLAGS, 8'h01);
    wt(4, 11'h001, 20, c);
    wrap_up();
  end
endmodule : liion_charge_cycle_control_test
